// ### include/ulbc_defs.svh
// Purpose: constants of the bus control block
// Assumes: mclk at 40 MHz
// Notes: timing counts derive from printed times
`ifndef ULBC_DEFS_SVH
`define ULBC_DEFS_SVH

// ==========================================================
// clock and reset timing
`define ULBC_MCLK_MHZ 40
`define ULBC_RST_MIN_NS 1000
// least time, so round up
`define ULBC_RST_MIN_CYC ((`ULBC_RST_MIN_NS * `ULBC_MCLK_MHZ + 999) / 1000)
`define ULBC_CNT_W 8
// bus clock divider: half period in mclk cycles
`define ULBC_BUS_DIV 2
`define ULBC_DIV_W 4

// ==========================================================
// data bus
`define ULBC_DATA_W 8
`define ULBC_FIFO_DEPTH 8
`define ULBC_CMD_IDLE 8'h00

`endif

// ### include/ulbc_pkg.sv
// Purpose: types of the bus control block
// Assumes: ulbc_defs.svh on the include path
// Notes: whole module state is one packed struct
`include "ulbc_defs.svh"

package ulbc_pkg;

  // ========================================================
  // bus ownership sequence
  typedef enum logic [2:0] {
    ULBC_IDLE,
    ULBC_ACCEPT,
    ULBC_TURN_UP,
    ULBC_SEND,
    ULBC_TURN_DOWN
  } ulbc_state_t;

  // ========================================================
  // one stream byte with its end marker
  typedef struct packed {
    logic last;
    logic [`ULBC_DATA_W-1:0] data;
  } ulbc_word_t;

  // ========================================================
  // top level state
  typedef struct packed {
    ulbc_state_t state;
    logic sync1;
    logic sync2;
    logic [`ULBC_CNT_W-1:0] low_cnt;
    logic clear;
    logic [`ULBC_DIV_W-1:0] div_cnt;
    logic clk_out;
    logic ref_prev;
    logic tick;
    logic pins_oe;
    logic clk_oe;
    logic dir;
    logic nxt;
    logic data_oe;
    logic [`ULBC_DATA_W-1:0] data_out;
    logic regs_on;
    logic rx_ready;
    logic pend_valid;
    logic [`ULBC_DATA_W-1:0] pend_data;
    logic push;
    ulbc_word_t push_word;
  } ulbc_top_st_t;

endpackage : ulbc_pkg

// ### logic/ulbc_fifo.sv
// Purpose: flip-flop fifo for bytes taken from the link
// Assumes: single clock, synchronous active-low reset
// Notes: flush empties it in one cycle
`timescale 1ns/1ps
`default_nettype none

module ulbc_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  output logic [$clog2(DEPTH+1)-1:0] fill
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
  } ulbc_fifo_st_t;

  ulbc_fifo_st_t s_reg;
  ulbc_fifo_st_t s_next;
  logic do_wr;
  logic do_rd;

  // ========================================================
  // handshake
  assign in_ready = (s_reg.cnt != CW'(DEPTH));
  assign out_valid = (s_reg.cnt != '0);
  assign out_data = s_reg.mem[s_reg.rd];
  assign fill = s_reg.cnt;
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // ========================================================
  // pointers and storage
  always_comb begin
    s_next = s_reg;
    if (do_wr) begin
      s_next.mem[s_reg.wr] = in_data;
      s_next.wr = (s_reg.wr == AW'(DEPTH-1)) ? '0 : s_reg.wr + AW'(1);
    end
    if (do_rd) begin
      s_next.rd = (s_reg.rd == AW'(DEPTH-1)) ? '0 : s_reg.rd + AW'(1);
    end
    case ({do_wr, do_rd})
      2'b10: s_next.cnt = s_reg.cnt + CW'(1);
      2'b01: s_next.cnt = s_reg.cnt - CW'(1);
      default: s_next.cnt = s_reg.cnt;
    endcase
    // stale entries need no clearing, only the pointers and the count
    if (flush) begin
      s_next.wr = '0;
      s_next.rd = '0;
      s_next.cnt = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : ulbc_fifo

`default_nettype wire

// ### logic/ulbc_top.sv
// Purpose: phy-side control of the parallel link bus
// Assumes: one clock mclk; pins synchronous except chip_reset_low
// Notes: bus clock is an enable-timed output, not a true 60 MHz
`timescale 1ns/1ps
`default_nettype none
`include "ulbc_defs.svh"

// Notes on behaviour
// - reset pin low: suspended, regulators off
// - reset pin is asynchronous, synchronised inside
// - low 1 us then release resets state
// - reset pin high: normal bus operation
// - stop means previous byte was last
// - data to send: drive dir high
// - nothing to send: dir low, watch bus
// - reset pin low: all bus pins tri-stated
// - clock-in mode: bus clock from reference input
// - bus outputs change on bus clock rise
// - nxt asserted in byte acceptance cycle
module ulbc_top
  import ulbc_pkg::*;
#(
  parameter int DEPTH = `ULBC_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic chip_reset_low,
  input wire logic clk_in_mode,
  input wire logic reference_clock_in,
  output logic bus_clock_out,
  output logic bus_clock_oe,
  input wire logic stp,
  input wire logic [`ULBC_DATA_W-1:0] data_in,
  output logic [`ULBC_DATA_W-1:0] data_out,
  output logic data_oe,
  output logic dir,
  output logic dir_oe,
  output logic nxt,
  output logic nxt_oe,
  output logic reg_3v3_en,
  output logic reg_1v8_en,
  output logic suspended,
  input wire logic rx_valid,
  input wire ulbc_word_t rx_word,
  output logic rx_ready,
  output logic tx_valid,
  output var ulbc_word_t tx_word,
  input wire logic tx_ready
);

  localparam int CW = $clog2(DEPTH+1);
  localparam logic [`ULBC_CNT_W-1:0] RST_MIN = `ULBC_CNT_W'(`ULBC_RST_MIN_CYC);
  localparam logic [`ULBC_DIV_W-1:0] DIV_LAST = `ULBC_DIV_W'(`ULBC_BUS_DIV - 1);

  ulbc_top_st_t s_reg;
  ulbc_top_st_t s_next;
  logic fifo_in_ready;
  logic [CW-1:0] fifo_fill;
  logic [$bits(ulbc_word_t)-1:0] fifo_out;
  logic held_low;

  // ========================================================
  // link byte buffer
  ulbc_fifo #(
    .W($bits(ulbc_word_t)),
    .DEPTH(DEPTH)
  ) i_ulbc_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .flush(s_reg.clear),
    .in_valid(s_reg.push),
    .in_data(s_reg.push_word),
    .in_ready(fifo_in_ready),
    .out_valid(tx_valid),
    .out_data(fifo_out),
    .out_ready(tx_ready),
    .fill(fifo_fill)
  );

  assign tx_word = ulbc_word_t'(fifo_out);
  assign held_low = !s_reg.sync2;

  // ========================================================
  // output pins, all straight from state flops
  assign bus_clock_out = s_reg.clk_out;
  assign bus_clock_oe = s_reg.clk_oe;
  assign data_out = s_reg.data_out;
  assign data_oe = s_reg.data_oe;
  assign dir = s_reg.dir;
  assign dir_oe = s_reg.pins_oe;
  assign nxt = s_reg.nxt;
  assign nxt_oe = s_reg.pins_oe;
  assign reg_3v3_en = s_reg.regs_on;
  assign reg_1v8_en = s_reg.regs_on;
  assign suspended = !s_reg.regs_on;
  assign rx_ready = s_reg.rx_ready;

  // ========================================================
  // next state
  always_comb begin
    logic push_now;
    logic [CW:0] need;
    logic room;
    s_next = s_reg;
    push_now = 1'b0;
    need = '0;
    room = 1'b0;
    s_next.push = 1'b0;
    s_next.rx_ready = 1'b0;
    s_next.clear = 1'b0;

    // pin may move at any time; first flop only feeds the second
    s_next.sync1 = chip_reset_low;
    s_next.sync2 = s_reg.sync1;

    // pulse width filter, shorter glitches only suspend and do not flush
    if (held_low) begin
      if (s_reg.low_cnt != RST_MIN) begin
        s_next.low_cnt = s_reg.low_cnt + `ULBC_CNT_W'(1);
      end
    end else begin
      s_next.clear = (s_reg.low_cnt == RST_MIN);
      s_next.low_cnt = '0;
    end

    s_next.regs_on = !held_low;
    s_next.pins_oe = !held_low;
    // clock pin is tied high in clock-in mode; driving it would fight
    s_next.clk_oe = !held_low && !clk_in_mode;

    // bus clock rise becomes a one-cycle tick
    s_next.ref_prev = reference_clock_in;
    if (clk_in_mode) begin
      s_next.clk_out = 1'b0;
      s_next.div_cnt = '0;
      s_next.tick = reference_clock_in && !s_reg.ref_prev;
    end else if (s_reg.div_cnt == DIV_LAST) begin
      s_next.div_cnt = '0;
      s_next.clk_out = !s_reg.clk_out;
      s_next.tick = !s_reg.clk_out;
    end else begin
      s_next.div_cnt = s_reg.div_cnt + `ULBC_DIV_W'(1);
      s_next.tick = 1'b0;
    end

    if (held_low || s_reg.clear) begin
      // suspended or just reset: bus idle; buffer flushed only when just reset
      s_next.state = ULBC_IDLE;
      s_next.dir = 1'b0;
      s_next.nxt = 1'b0;
      s_next.data_oe = 1'b0;
      s_next.pend_valid = 1'b0;
    end else if (s_reg.tick) begin
      case (s_reg.state)
        ULBC_IDLE: begin
          s_next.dir = 1'b0;
          s_next.data_oe = 1'b0;
          // link command first; it cannot be refused once seen
          if (data_in != `ULBC_CMD_IDLE) begin
            s_next.state = ULBC_ACCEPT;
            s_next.nxt = fifo_in_ready;
          end else if (rx_valid) begin
            s_next.dir = 1'b1;
            s_next.state = ULBC_TURN_UP;
          end
        end
        ULBC_ACCEPT: begin
          if (stp) begin
            // byte of the previous cycle closes the stream
            s_next.nxt = 1'b0;
            s_next.state = ULBC_IDLE;
            s_next.pend_valid = 1'b0;
            if (s_reg.pend_valid) begin
              s_next.push = 1'b1;
              s_next.push_word = '{last: 1'b1, data: s_reg.pend_data};
            end
          end else begin
            if (s_reg.nxt) begin
              // hold one byte back until stop or next byte tells
              push_now = s_reg.pend_valid;
              s_next.push = push_now;
              s_next.push_word = '{last: 1'b0, data: s_reg.pend_data};
              s_next.pend_valid = 1'b1;
              s_next.pend_data = data_in;
            end
            // room for held byte plus one more
            need = {1'b0, fifo_fill} + (CW+1)'(push_now)
              + (CW+1)'(s_next.pend_valid);
            room = fifo_in_ready && (need < (CW+1)'(DEPTH));
            s_next.nxt = room;
          end
        end
        ULBC_TURN_UP: begin
          s_next.data_oe = 1'b1;
          s_next.data_out = rx_word.data;
          s_next.rx_ready = 1'b1;
          s_next.state = rx_word.last ? ULBC_TURN_DOWN : ULBC_SEND;
        end
        ULBC_SEND: begin
          // an empty source ends the stream early
          if (rx_valid) begin
            s_next.data_out = rx_word.data;
            s_next.rx_ready = 1'b1;
            s_next.state = rx_word.last ? ULBC_TURN_DOWN : ULBC_SEND;
          end else begin
            s_next.state = ULBC_TURN_DOWN;
          end
        end
        ULBC_TURN_DOWN: begin
          s_next.data_oe = 1'b0;
          s_next.dir = 1'b0;
          s_next.state = ULBC_IDLE;
        end
        default: begin
          s_next.state = ULBC_IDLE;
        end
      endcase
    end
  end

  // ========================================================
  // state register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : ulbc_top

`default_nettype wire

// ### sim/ulbc_top_props.sv
// Purpose: pin checks for ulbc_top
// Assumes: mclk domain only
// Notes: transfers are judged by the bench
`timescale 1ns/1ps
`default_nettype none
// =====
// checker
module ulbc_top_props (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic chip_reset_low,
  input wire logic clk_in_mode,
  input wire logic bus_clock_out,
  input wire logic bus_clock_oe,
  input wire logic data_oe,
  input wire logic dir,
  input wire logic dir_oe,
  input wire logic nxt,
  input wire logic nxt_oe,
  input wire logic reg_3v3_en,
  input wire logic reg_1v8_en,
  input wire logic suspended
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_regs_pair: assert property (
    reg_3v3_en == reg_1v8_en && suspended == !reg_3v3_en)
    else $error("regulator enables disagree");
  a_low_off: assert property (
    !chip_reset_low [*3] |=> !dir_oe && !nxt_oe && !data_oe && suspended
    && !bus_clock_oe)
    else $error("pins driven in chip reset");
  a_power_up: assert property (
    chip_reset_low [*4] |-> dir_oe && nxt_oe && reg_1v8_en)
    else $error("pins idle after chip reset");
  a_data_own: assert property (
    data_oe |-> dir)
    else $error("data driven without dir");
  a_nxt_idle: assert property (
    nxt |-> !dir)
    else $error("nxt while phy owns bus");
  a_clkin_quiet: assert property (
    clk_in_mode [*2] |-> !bus_clock_out && !bus_clock_oe)
    else $error("bus clock made in clock-in mode");
  a_clk_div: assert property (
    @(posedge mclk) disable iff (!rst_b || clk_in_mode || !chip_reset_low)
    $rose(bus_clock_out) |=> bus_clock_out ##1 !bus_clock_out)
    else $error("bus clock period wrong");
  a_turn_data: assert property (
    @(posedge mclk) disable iff (!rst_b || !chip_reset_low)
    $rose(dir) |-> ##[1:6] data_oe)
    else $error("no data after turnaround");
endmodule : ulbc_top_props
bind ulbc_top ulbc_top_props i_ulbc_top_props (.mclk, .rst_b,
  .chip_reset_low, .clk_in_mode, .bus_clock_out, .bus_clock_oe, .data_oe,
  .dir, .dir_oe,
  .nxt, .nxt_oe, .reg_3v3_en, .reg_1v8_en, .suspended);
`default_nettype wire

// ### sim/ulbc_link_model.sv
// Purpose: link controller on the parallel bus
// Assumes: acts one mclk after bus clock rise
// Notes: bench fills q, reads got
`timescale 1ns/1ps
`default_nettype none
// =====
// link model
module ulbc_link_model (
  input wire logic mclk,
  input wire logic bus_clock_out,
  input wire logic dir,
  input wire logic nxt,
  input wire logic data_oe,
  input wire logic [7:0] data_out,
  output logic stp,
  output logic [7:0] data_in
);
  logic prev = 1'b0;
  logic stp_q = 1'b0;
  logic [7:0] drv = 8'h00;
  logic [7:0] q[$];
  logic [7:0] got[$];
  assign stp = stp_q;
  // released bus shows inverse, not a stale byte
  assign data_in = data_oe ? data_out : (dir ? ~drv : drv);
  always @(posedge mclk) begin
    prev <= bus_clock_out;
    if (bus_clock_out && !prev) begin
      if (data_oe) got.push_back(data_out);
      if (stp) begin
        stp_q <= 1'b0;
      end else if (drv != 8'h00 && nxt) begin
        if (q.size() > 0) drv <= q.pop_front();
        else begin
          drv <= 8'h00;
          stp_q <= 1'b1;
        end
      end else if (drv == 8'h00 && !dir && q.size() > 0) begin
        drv <= q.pop_front();
      end
    end
  end
endmodule : ulbc_link_model
`default_nettype wire

// ### sim/ulbc_top_tb_top.sv
// Purpose: self-checking bench for ulbc_top
// Assumes: clock-out mode for traffic
// Notes: clock-in mode: quiet bus clock pin and one short send
`timescale 1ns/1ps
`default_nettype none
// =====
// bench
module ulbc_top_tb_top;
  import ulbc_pkg::*;
  logic mclk = 1'b0, rst_b = 1'b0, chip_reset_low = 1'b1, clk_in_mode = 1'b0;
  logic reference_clock_in = 1'b0, rx_valid = 1'b0, tx_ready = 1'b0;
  ulbc_word_t rx_word = '0, tx_word;
  logic bus_clock_out, bus_clock_oe, stp, data_oe, dir, dir_oe, nxt, nxt_oe;
  logic reg_3v3_en, reg_1v8_en, suspended, rx_ready, tx_valid;
  logic [7:0] data_in, data_out;
  int mismatches = 0, total_checks = 0, cycles = 0;
  always #12.5 mclk = ~mclk;
  ulbc_top i_ulbc_top (.mclk, .rst_b, .chip_reset_low, .clk_in_mode,
    .reference_clock_in, .bus_clock_out, .bus_clock_oe, .stp, .data_in,
    .data_out, .data_oe, .dir, .dir_oe, .nxt, .nxt_oe, .reg_3v3_en,
    .reg_1v8_en, .suspended, .rx_valid, .rx_word, .rx_ready, .tx_valid,
    .tx_word, .tx_ready);
  ulbc_link_model i_ulbc_link_model (.mclk, .bus_clock_out, .dir, .nxt,
    .data_oe, .data_out, .stp, .data_in);
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // hang guard, the tests need some 600 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("[ERR] %0t: timeout", $time);
      conclude();
    end
  end
  task automatic t_link_in;
    int i, n;
    for (i = 0; i < 12; i++) i_ulbc_link_model.q.push_back(8'hA0 + 8'(i));
    repeat (300) @(posedge mclk);
    chk(i_ulbc_link_model.q.size() > 0, 1'b1);
    chk({nxt, tx_valid}, 2'h1);
    tx_ready <= 1'b1;
    i = 0;
    for (n = 0; n < 2000 && i < 12; n++) begin
      @(posedge mclk);
      if (tx_valid === 1'b1) begin
        chk(tx_word, {i == 11, 8'hA0 + 8'(i)});
        i++;
      end
    end
    tx_ready <= 1'b0;
    chk(i == 12, 1'b1);
    $display("test link_in done");
  endtask : t_link_in
  task automatic t_phy_out;
    int i, n;
    rx_word <= {1'b0, 8'hC0};
    rx_valid <= 1'b1;
    i = 0;
    for (n = 0; n < 400 && i < 3; n++) begin
      @(posedge mclk);
      if (rx_ready === 1'b1) begin
        i++;
        rx_word <= {i == 2, 8'hC0 + 8'(i)};
        rx_valid <= i < 3;
      end
    end
    repeat (20) @(posedge mclk);
    chk(dir, 1'b0);
    chk(i_ulbc_link_model.got.size(), 3);
    for (i = 0; i < 3; i++) chk(i_ulbc_link_model.got[i], 8'hC0 + 8'(i));
    $display("test phy_out done");
  endtask : t_phy_out
  task automatic t_chip_reset;
    int i;
    for (i = 0; i < 3; i++) i_ulbc_link_model.q.push_back(8'h51 + 8'(i));
    repeat (80) @(posedge mclk);
    chip_reset_low <= 1'b0;
    repeat (10) @(posedge mclk);
    chk({suspended, reg_3v3_en, dir_oe, nxt_oe, data_oe}, 5'h10);
    chk({reg_1v8_en, bus_clock_oe}, 2'h0);
    chip_reset_low <= 1'b1;
    repeat (10) @(posedge mclk);
    chk(tx_valid, 1'b1);
    chip_reset_low <= 1'b0;
    repeat (50) @(posedge mclk);
    chip_reset_low <= 1'b1;
    repeat (10) @(posedge mclk);
    chk({tx_valid, dir_oe}, 2'h1);
    $display("test chip_reset done");
  endtask : t_chip_reset
  task automatic t_clk_in;
    int n, seen;
    seen = 0;
    clk_in_mode <= 1'b1;
    rx_word <= {1'b1, 8'h3C};
    rx_valid <= 1'b1;
    // ticks now come from the reference input, one rise every 4 mclk
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (n % 2 == 1) reference_clock_in <= ~reference_clock_in;
      if (n > 1) chk({bus_clock_oe, bus_clock_out}, 2'h0);
      if (rx_ready === 1'b1) begin
        seen++;
        chk({dir, data_out}, {1'b1, 8'h3C});
        rx_valid <= 1'b0;
      end
    end
    chk(seen, 1);
    chk(dir, 1'b0);
    clk_in_mode <= 1'b0;
    $display("test clk_in done");
  endtask : t_clk_in
  initial begin
    repeat (5) @(posedge mclk);
    chk(suspended, 1'b1);
    rst_b <= 1'b1;
    repeat (5) @(posedge mclk);
    chk({dir_oe, bus_clock_oe, suspended, dir}, 4'hC);
    $display("test reset done");
    t_link_in();
    t_phy_out();
    t_chip_reset();
    t_clk_in();
    conclude();
  end
endmodule : ulbc_top_tb_top
`default_nettype wire
